// ===== logic/sacr_pkg.sv
// Purpose: Shared constants for the sampling converter control block
// Assumes: 25 MHz system clock
// Notes: Times in ns, cycle counts derived from the clock period
package sacr_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RES_WIDTH = 12;
  // Conversion time from start rising edge to end of conversion
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  // Reacquisition time the host must leave after busy rises
  localparam int REACQ_TIME_NS = 333;
  localparam int REACQ_CYCLES =
    (REACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data drives this many cycles ahead of busy rising
  localparam int DATA_LEAD_CYCLES = 1;
  localparam logic [11:0] RES_RESET = 12'h000;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  typedef enum logic [1:0] {
    SACR_TRACK,
    SACR_HOLD,
    SACR_CONVERT
  } sacr_state_type;
endpackage

// ===== logic/sacr_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sacr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= INIT;
      sync_o <= INIT;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== logic/sacr_ctrl.sv
// Purpose: Conversion control and three-state read of a 12-bit converter
// Assumes: Start, select and read pins are asynchronous; the sampled
//   analog value arrives as a 12-bit unipolar word from the quantiser
// Notes:
// Notes on behaviour
// - Falling edge of start moves the track/hold into hold.
// - Conversion begins only on the rising edge of start.
// - Busy is low for the whole of a conversion.
// - Busy rises only once the new result sits in the output latch.
// - Track/hold tracks again after conversion until the next start falls.
// - Select and read both low enable the output drivers.
// - Output drivers stay off during conversion until the result latches, one cycle before busy rises.
// - With select and read tied low, bus floats during each conversion except its last cycle.
// - Data drives before busy rises so busy can clock external latches.
// - Bipolar range gives offset binary, zero at the mid-scale transition.
// - Unipolar ranges give natural binary, one step is full scale / 4096.
`timescale 1ns/1ps
`default_nettype none
module sacr_ctrl #(
  parameter int CONV_CYCLES = sacr_pkg::CONV_CYCLES,
  parameter int LEAD_CYCLES = sacr_pkg::DATA_LEAD_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic conversion_start_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic bipolar_i,
  input wire logic [sacr_pkg::RES_WIDTH-1:0] sample_i,
  output logic hold_o,
  output logic busy_n_o,
  output logic [sacr_pkg::RES_WIDTH-1:0] data_o,
  output logic data_oe_o
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  localparam logic [CW-1:0] LATCH_AT = CW'(CONV_CYCLES - 1 - LEAD_CYCLES);

  logic [2:0] pins_s;
  logic start_n_s;
  logic cs_n_s;
  logic rd_n_s;
  logic start_n_prev_q;
  logic start_fall;
  logic start_rise;
  sacr_pkg::sacr_state_type state_q;
  logic [CW-1:0] count_q;
  logic [sacr_pkg::RES_WIDTH-1:0] held_q;
  logic [sacr_pkg::RES_WIDTH-1:0] result_q;
  logic result_ready_q;

  // Pins are not on our clock, so all pass two flops
  sacr_sync #(
    .WIDTH(3),
    .INIT(3'h7)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({conversion_start_n_i, chip_select_n_i, read_n_i}),
    .sync_o(pins_s)
  );
  assign start_n_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign rd_n_s = pins_s[0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_n_prev_q <= 1'b1;
    end else begin
      start_n_prev_q <= start_n_s;
    end
  end
  assign start_fall = start_n_prev_q & ~start_n_s;
  assign start_rise = ~start_n_prev_q & start_n_s;

  // Starts during a conversion are ignored; the host must not issue them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= sacr_pkg::SACR_TRACK;
    end else begin
      unique case (state_q)
        sacr_pkg::SACR_TRACK: begin
          if (start_fall) begin
            state_q <= sacr_pkg::SACR_HOLD;
          end
        end
        sacr_pkg::SACR_HOLD: begin
          if (start_rise) begin
            state_q <= sacr_pkg::SACR_CONVERT;
          end
        end
        sacr_pkg::SACR_CONVERT: begin
          if (count_q == CONV_LAST) begin
            state_q <= sacr_pkg::SACR_TRACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= '0;
    end else if (state_q == sacr_pkg::SACR_CONVERT) begin
      count_q <= count_q + CW'(1);
    end else begin
      count_q <= '0;
    end
  end

  // Sample frozen at the hold edge; later input changes do not matter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      held_q <= sacr_pkg::RES_RESET;
    end else if (state_q == sacr_pkg::SACR_TRACK && start_fall) begin
      held_q <= sample_i;
    end
  end

  // Result latched ahead of the end so the bus settles before busy rises
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      result_q <= sacr_pkg::RES_RESET;
      result_ready_q <= 1'b1;
    end else if (state_q == sacr_pkg::SACR_HOLD && start_rise) begin
      result_ready_q <= 1'b0;
    end else if (state_q == sacr_pkg::SACR_CONVERT &&
                 count_q == LATCH_AT) begin
      // Offset binary is the natural code with the top bit inverted
      result_q <= bipolar_i ? (held_q ^ sacr_pkg::BIPOLAR_FLIP)
                            : held_q;
      result_ready_q <= 1'b1;
    end
  end

  assign data_o = result_q;
  assign hold_o = (state_q != sacr_pkg::SACR_TRACK);
  assign busy_n_o = (state_q != sacr_pkg::SACR_CONVERT);
  // Drivers off while a conversion has not yet produced its result
  assign data_oe_o = ~cs_n_s & ~rd_n_s & result_ready_q;

  AST_BUSY_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(busy_n_o) |-> !busy_n_o [*8] ##18 busy_n_o)
    else $error("busy low length wrong");
  AST_NO_DRIVE_CONV: assert property (@(posedge clk_i)
    disable iff (reset_i) $fell(busy_n_o) |-> !data_oe_o [*8])
    else $error("bus driven during conversion");
  AST_DRIVE_BEFORE_BUSY: assert property (@(posedge clk_i)
    disable iff (reset_i) $rose(busy_n_o) && !cs_n_s && !rd_n_s
    && $past(!cs_n_s && !rd_n_s) |-> $past(data_oe_o))
    else $error("data not driven before busy rose");
  AST_READ_ENABLE: assert property (@(posedge clk_i)
    disable iff (reset_i) busy_n_o && !cs_n_s && !rd_n_s
    && state_q != sacr_pkg::SACR_HOLD |-> data_oe_o)
    else $error("read did not enable drivers");
  AST_HOLD_ON_FALL: assert property (@(posedge clk_i)
    disable iff (reset_i) state_q == sacr_pkg::SACR_TRACK && start_fall
    |=> hold_o && busy_n_o)
    else $error("hold not entered on start fall");
  AST_WAIT_RISE: assert property (@(posedge clk_i)
    disable iff (reset_i) hold_o && busy_n_o && !start_rise |=> busy_n_o)
    else $error("conversion began before start rose");
  AST_BUSY_ON_RISE: assert property (@(posedge clk_i)
    disable iff (reset_i) state_q == sacr_pkg::SACR_HOLD && start_rise
    |=> !busy_n_o [*3])
    else $error("busy not low after start rise");
  AST_TRACK_AFTER: assert property (@(posedge clk_i)
    disable iff (reset_i) $rose(busy_n_o) |-> !hold_o)
    else $error("track not resumed at end of conversion");
  AST_RESULT_READY: assert property (@(posedge clk_i)
    disable iff (reset_i) $rose(busy_n_o) |-> result_ready_q
    && $stable(result_q))
    else $error("result not latched when busy rose");
  AST_CODE: assert property (@(posedge clk_i)
    disable iff (reset_i) $rose(result_ready_q) && !bipolar_i
    |-> result_q == held_q)
    else $error("unipolar code not natural binary");
endmodule
`default_nettype wire

// ===== test/sacr_host.sv
// Purpose: Host model driving start, select and read pins
// Assumes: Pins change just after a rising clock edge
// Notes: Never starts while busy is low
`timescale 1ns/1ps
`default_nettype none
module sacr_host (
  input wire logic clk_i,
  input wire logic busy_n_i,
  output logic start_n_o,
  output logic cs_n_o,
  output logic rd_n_o
);
  initial begin
    start_n_o = 1'b1;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
  end
  // Low time sets hold settling, so keep it above the sync delay
  task automatic pulse(input int low);
    @(posedge clk_i);
    if (busy_n_i === 1'b1) start_n_o <= 1'b0;
    repeat (low) @(posedge clk_i);
    start_n_o <= 1'b1;
  endtask
  task automatic bus(input logic on);
    @(posedge clk_i);
    cs_n_o <= ~on;
    rd_n_o <= ~on;
  endtask
  // Reacquire before the next start
  task automatic rest();
    repeat (sacr_pkg::REACQ_CYCLES) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Default conversion length of 25 cycles
// Notes: Pins come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic reset_i;
  logic bipolar_i;
  logic [11:0] sample_i;
  wire logic start_n, cs_n, rd_n, hold_o, busy_n_o, data_oe_o;
  wire logic [11:0] data_o;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #20 clk_i = ~clk_i;
  sacr_ctrl uut (.clk_i(clk_i), .reset_i(reset_i),
    .conversion_start_n_i(start_n), .chip_select_n_i(cs_n),
    .read_n_i(rd_n), .bipolar_i(bipolar_i), .sample_i(sample_i),
    .hold_o(hold_o), .busy_n_o(busy_n_o), .data_o(data_o),
    .data_oe_o(data_oe_o));
  sacr_host host (.clk_i(clk_i), .busy_n_i(busy_n_o), .start_n_o(start_n),
    .cs_n_o(cs_n), .rd_n_o(rd_n));
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Tied mode checks the bus around busy; else a read follows
  task automatic t_conv(input logic [11:0] s, input logic bip,
                        input logic tied);
    logic [11:0] exp;
    logic [11:0] d_end;
    logic oe0;
    logic oe_end;
    int n;
    exp = bip ? (s ^ 12'h800) : s;
    oe_end = 1'b0;
    d_end = 12'h000;
    n = 0;
    if (tied) host.bus(1'b1);
    @(posedge clk_i);
    sample_i <= s;
    bipolar_i <= bip;
    host.pulse(6);
    #1;
    chk({11'h000, hold_o}, 12'h001);
    chk({11'h000, busy_n_o}, 12'h001);
    while (busy_n_o !== 1'b0 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    n = 0;
    oe0 = data_oe_o;
    while (busy_n_o === 1'b0 && n < 40) begin
      chk({11'h000, hold_o}, 12'h001);
      oe_end = data_oe_o;
      d_end = data_o;
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n[11:0], 12'(sacr_pkg::CONV_CYCLES));
    chk({11'h000, hold_o}, 12'h000);
    if (tied) begin
      chk({11'h000, oe0}, 12'h000);
      chk({11'h000, oe_end}, 12'h001);
      chk(d_end, exp);
      host.bus(1'b0);
    end else begin
      chk({11'h000, data_oe_o}, 12'h000);
      host.bus(1'b1);
      repeat (3) @(posedge clk_i);
      #1;
      chk({11'h000, data_oe_o}, 12'h001);
      chk(data_o, exp);
      host.bus(1'b0);
    end
    host.rest();
    $display("conversion test done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    reset_i <= 1'b1;
    bipolar_i <= 1'b0;
    sample_i <= 12'h000;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({9'h000, hold_o, busy_n_o, data_oe_o}, 12'h002);
    $display("reset test done");
    t_conv(12'h7FF, 1'b1, 1'b0);
    t_conv(12'h800, 1'b1, 1'b0);
    t_conv(12'hFFF, 1'b0, 1'b0);
    t_conv(12'h001, 1'b0, 1'b1);
    t_conv(12'hA5C, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
